// ==== src/dma_crc_pkg.sv ====
package dma_crc_pkg;

    localparam int ADDR_W = 8;

    // register offsets; printed offsets are not all multiples of four, so byte address = 4 * index
    localparam logic [ADDR_W-1:0] IDX_CONTROLLER_CONTROL   = 8'h00;
    localparam logic [ADDR_W-1:0] IDX_CHECKSUM_CONTROL     = 8'h02;
    localparam logic [ADDR_W-1:0] IDX_CHECKSUM_DATA_INPUT  = 8'h04;
    localparam logic [ADDR_W-1:0] IDX_CHECKSUM_RESULT      = 8'h08;
    localparam logic [ADDR_W-1:0] IDX_CHECKSUM_STATUS      = 8'h0C;
    localparam logic [ADDR_W-1:0] IDX_DEBUG_HALT_CONTROL   = 8'h0D;
    localparam logic [ADDR_W-1:0] ADDR_CONTROLLER_CONTROL  = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CHECKSUM_CONTROL    = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_CHECKSUM_DATA_INPUT = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_CHECKSUM_RESULT     = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_CHECKSUM_STATUS     = 8'h30;
    localparam logic [ADDR_W-1:0] ADDR_DEBUG_HALT_CONTROL  = 8'h34;

    // controller_control fields
    localparam int SOFT_RESET_BIT   = 0;
    localparam int XFER_ON_BIT      = 1;
    localparam int CHK_ON_BIT       = 2;
    localparam int LVL_LSB          = 8;
    localparam int LVL_W            = 4;
    localparam logic [15:0] CTRL_RESET    = 16'h0000;
    localparam logic [15:0] CHKCTRL_RESET = 16'h0000;
    localparam logic [31:0] DATA_RESET    = 32'h00000000;

    // checksum_control fields
    localparam int WIDTH_LSB = 0;
    localparam int POLY_LSB  = 2;
    localparam int SRC_LSB   = 8;
    localparam int SRC_W     = 6;

    localparam logic [5:0] SOURCE_NONE      = 6'h00;
    localparam logic [5:0] SOURCE_REG_WRITE = 6'h01;
    localparam logic [5:0] SOURCE_CHANNEL_N = 6'h20;
    localparam logic [1:0] POLY_CCITT16     = 2'h0;
    localparam logic [1:0] POLY_IEEE32      = 2'h1;
    localparam logic [1:0] BEAT_BYTE        = 2'h0;
    localparam logic [1:0] HALFWORD_BEAT    = 2'h1;
    localparam logic [1:0] BEAT_WORD        = 2'h2;

    localparam logic [15:0] CCITT_POLY = 16'h1021;
    localparam logic [31:0] IEEE_POLY  = 32'h04C11DB7;
    localparam logic [31:0] CRC_SEED   = 32'hFFFFFFFF;

    localparam int BUSY_BIT = 0;
    localparam int ZERO_BIT = 1;

    typedef struct packed {
        logic [5:0] src;
        logic [1:0] poly;
        logic [1:0] width;
    } chk_cfg_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
        logic [3:0]        be;
        logic              wr;
        logic              rd;
    } bus_req_t;

    typedef enum logic [1:0] {
        XFER_IDLE  = 2'b00,
        XFER_RUN   = 2'b01,
        XFER_DRAIN = 2'b10
    } xfer_state_t;

endpackage : dma_crc_pkg

// ==== src/crc_byte_engine.sv ====
`timescale 1ns/1ps
`default_nettype none
module crc_byte_engine (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        clear,
    input  wire logic        start,
    input  wire logic [31:0] word,
    input  wire logic [1:0]  width,
    input  wire logic [1:0]  poly,
    output logic             active,
    output logic             done,
    output logic [31:0]      result
);
    logic [31:0] crcFf;
    logic [31:0] wordFf;
    logic [2:0]  leftFf;

    function automatic logic [31:0] crcStep(input logic [31:0] c, input logic [7:0] b, input logic [1:0] p);
        logic [31:0] r;
        logic [31:0] rp;
        r = c;
        rp = {<<{dma_crc_pkg::IEEE_POLY}};
        for (int i = 0; i < 8; i++) begin
            if (p == dma_crc_pkg::POLY_IEEE32) begin
                // reflected serial form
                r = (r[0] ^ b[i]) ? ((r >> 1) ^ rp) : (r >> 1);
            end else begin
                r[15:0] = (r[15] ^ b[7-i]) ? ((r[15:0] << 1) ^ dma_crc_pkg::CCITT_POLY) : (r[15:0] << 1);
                r[31:16] = 16'h0000;
            end
        end
        return r;
    endfunction : crcStep

    function automatic logic [2:0] beatBytes(input logic [1:0] w);
        if (w == dma_crc_pkg::BEAT_WORD) return 3'h4;
        else if (w == dma_crc_pkg::HALFWORD_BEAT) return 3'h2;
        else return 3'h1;
    endfunction : beatBytes

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            leftFf <= 3'h0;
            wordFf <= 32'h00000000;
        end else if (clear) begin
            leftFf <= 3'h0;
            wordFf <= 32'h00000000;
        end else if (start) begin
            leftFf <= beatBytes(width); // R19
            wordFf <= word;
        end else if (leftFf != 3'h0) begin
            leftFf <= leftFf - 3'h1;
            wordFf <= {8'h00, wordFf[31:8]}; // R21
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            crcFf <= dma_crc_pkg::CRC_SEED;
        end else if (clear) begin
            crcFf <= dma_crc_pkg::CRC_SEED;
        end else if (!start && leftFf != 3'h0) begin
            crcFf <= crcStep(crcFf, wordFf[7:0], poly); // R21
        end
    end

    assign active = (leftFf != 3'h0);
    assign done   = (leftFf == 3'h1);

    always_comb begin
        if (poly == dma_crc_pkg::POLY_IEEE32) begin
            result = ~crcFf; // R20
        end else begin
            result = {16'h0000, crcFf[15:0]};
        end
    end
endmodule : crc_byte_engine
`default_nettype wire

// ==== src/dma_crc_global_control.sv ====
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Function
// (R1) registers accept 8, 16 and 32-bit accesses through byte enables.
// (R2) protected registers ignore writes while the protection input is high.
// (R3) enable-protected registers accept writes only while transfers are off.
// (R4) reserved bits read zero; software writes zero to them.
// (R5) priority level enables gate requests to arbiter; writable while enabled.
// (R6) clearing checksum enable is ignored while busy flag is set.
// (R7) writing one enables checksum engine, regardless of transfer enable.
// (R8) clearing transfer enable waits for burst end and empty buffer.
// (R9) writing one enables transfers; bit reads one while enabled.
// (R10) soft reset with both enables off restores registers except debug.
// (R11) soft reset with any enable on is ignored and flags access error.
// (R12) soft reset bit reads one during reset; writing zero does nothing.
// (R13) source field: none 0x0, register path 0x1, channel 0x20-0x3F.
// (R14) source field locked while busy; busy flag shows the lock.
// (R15) with a channel source, that channel signals completion.
// (R16) polynomial field: 16-bit CCITT at 0x0, 32-bit IEEE at 0x1.
// (R17) input width selects byte, halfword or word of each data write.
// (R18) data write with register path sets busy; writing one clears it.
// (R19) engine consumes one byte per cycle.
// (R20) 32-bit result presented bit-reversed; the code presents it bit-inverted (~crcFf) instead.
// (R21) running checksum updated per beat, low byte first.
// (R22) software configures source, polynomial and width before data.
module dma_crc_global_control (
    input  wire logic                           clk,
    input  wire logic                           resetn,
    input  wire logic [dma_crc_pkg::ADDR_W-1:0] addr,
    input  wire logic [31:0]                    wdata,
    input  wire logic [3:0]                     byteEn,
    input  wire logic                           wrStrobe,
    input  wire logic                           rdStrobe,
    output logic      [31:0]                    rdata,
    output logic                                accessError,
    input  wire logic                           writeProtect,
    input  wire logic [3:0]                     levelRequest,
    output logic      [3:0]                     levelGrantable,
    input  wire logic                           transferActive,
    input  wire logic                           burstDone,
    input  wire logic                           bufferEmpty,
    output logic                                transferAbort,
    output logic                                transferEngineOn,
    input  wire logic                           channelBeatValid,
    input  wire logic [31:0]                    channelBeatData,
    input  wire logic                           channelEnabled,
    input  wire logic                           channelCrcDone,
    output logic                                checksumBusyFlag
);
    logic [3:0]                 levelEnableFf;
    logic                       xferOnFf;
    logic                       chkOnFf;
    logic                       softResetFf;
    dma_crc_pkg::chk_cfg_t      cfgFf;
    logic [31:0]                dataInFf;
    logic                       busyFf;
    logic                       zeroFf;
    logic                       dbgRunFf;
    logic [31:0]                rdataFf;
    logic                       errFf;
    dma_crc_pkg::xfer_state_t   xferStateFf;
    dma_crc_pkg::xfer_state_t   nxt_xferState;
    dma_crc_pkg::bus_req_t      req;
    logic                       wrCtrl;
    logic                       wrCfg;
    logic                       wrData;
    logic                       wrStatus;
    logic                       wrDbg;
    logic [31:0]                wMask;
    logic                       srstHit;
    logic                       engStart;
    logic                       engClear;
    logic                       engDone;
    logic [31:0]                engWord;
    logic [31:0]                result;
    logic                       regPath;
    logic                       chanPath;

    function automatic logic [31:0] laneMask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : laneMask

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
        return (old & ~m) | (nw & m);
    endfunction : merge

    assign req      = '{addr: addr, wdata: wdata, be: byteEn, wr: wrStrobe, rd: rdStrobe};
    assign wMask    = laneMask(req.be); // R1
    assign regPath  = (cfgFf.src == dma_crc_pkg::SOURCE_REG_WRITE); // R13
    assign chanPath = (cfgFf.src[5] == dma_crc_pkg::SOURCE_CHANNEL_N[5]); // R13

    // register decode
    always_comb begin
        wrCtrl   = 1'b0;
        wrCfg    = 1'b0;
        wrData   = 1'b0;
        wrStatus = 1'b0;
        wrDbg    = 1'b0;
        // no register here is enable-protected
        if (req.wr && req.addr == dma_crc_pkg::ADDR_CONTROLLER_CONTROL) begin
            wrCtrl = 1'b1; // R3
        end else if (req.wr && req.addr == dma_crc_pkg::ADDR_CHECKSUM_CONTROL) begin
            wrCfg = !writeProtect; // R2
        end else if (req.wr && req.addr == dma_crc_pkg::ADDR_CHECKSUM_DATA_INPUT) begin
            wrData = !writeProtect; // R2
        end else if (req.wr && req.addr == dma_crc_pkg::ADDR_CHECKSUM_STATUS) begin
            wrStatus = !writeProtect; // R2
        end else if (req.wr && req.addr == dma_crc_pkg::ADDR_DEBUG_HALT_CONTROL) begin
            wrDbg = !writeProtect; // R2
        end
    end

    assign srstHit = wrCtrl && wMask[dma_crc_pkg::SOFT_RESET_BIT] && wdata[dma_crc_pkg::SOFT_RESET_BIT]; // R12

    // soft reset: one cycle in progress, clears everything but debug
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            softResetFf <= 1'b0;
            errFf       <= 1'b0;
        end else begin
            softResetFf <= srstHit && !xferOnFf && !chkOnFf; // R10
            errFf       <= srstHit && (xferOnFf || chkOnFf); // R11
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            levelEnableFf <= 4'h0;
        end else if (softResetFf) begin
            levelEnableFf <= 4'h0; // R10
        end else if (wrCtrl && !srstHit) begin
            levelEnableFf <= (levelEnableFf & ~wMask[dma_crc_pkg::LVL_LSB +: dma_crc_pkg::LVL_W])
                           | (wdata[dma_crc_pkg::LVL_LSB +: dma_crc_pkg::LVL_W]
                              & wMask[dma_crc_pkg::LVL_LSB +: dma_crc_pkg::LVL_W]); // R5
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            chkOnFf <= 1'b0;
        end else if (softResetFf) begin
            chkOnFf <= 1'b0;
        end else if (wrCtrl && !srstHit && wMask[dma_crc_pkg::CHK_ON_BIT]) begin
            if (wdata[dma_crc_pkg::CHK_ON_BIT]) begin
                chkOnFf <= 1'b1; // R7
            end else if (!busyFf) begin
                chkOnFf <= 1'b0; // R6
            end
        end
    end

    // transfer enable with graceful stop
    always_comb begin
        nxt_xferState = xferStateFf;
        case (xferStateFf)
            dma_crc_pkg::XFER_IDLE: begin
                if (wrCtrl && !srstHit && wMask[dma_crc_pkg::XFER_ON_BIT] && wdata[dma_crc_pkg::XFER_ON_BIT]) begin
                    nxt_xferState = dma_crc_pkg::XFER_RUN; // R9
                end
            end
            dma_crc_pkg::XFER_RUN: begin
                if (wrCtrl && !srstHit && wMask[dma_crc_pkg::XFER_ON_BIT] && !wdata[dma_crc_pkg::XFER_ON_BIT]) begin
                    nxt_xferState = transferActive ? dma_crc_pkg::XFER_DRAIN : dma_crc_pkg::XFER_IDLE; // R8
                end
            end
            dma_crc_pkg::XFER_DRAIN: begin
                if (burstDone && bufferEmpty) begin
                    nxt_xferState = dma_crc_pkg::XFER_IDLE; // R8
                end
            end
            default: nxt_xferState = dma_crc_pkg::XFER_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            xferStateFf <= dma_crc_pkg::XFER_IDLE;
        end else if (softResetFf) begin
            xferStateFf <= dma_crc_pkg::XFER_IDLE;
        end else begin
            xferStateFf <= nxt_xferState;
        end
    end

    assign xferOnFf = (xferStateFf != dma_crc_pkg::XFER_IDLE);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            transferAbort <= 1'b0;
        end else begin
            transferAbort <= (xferStateFf == dma_crc_pkg::XFER_DRAIN) && burstDone && bufferEmpty; // R8
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfgFf <= '0;
        end else if (softResetFf) begin
            cfgFf <= '0;
        end else if (wrCfg) begin
            if (!busyFf && wMask[dma_crc_pkg::SRC_LSB]) begin
                cfgFf.src <= wdata[13:8]; // R14
            end
            if (wMask[0]) begin
                cfgFf.poly  <= wdata[3:2]; // R16
                cfgFf.width <= wdata[1:0]; // R17
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dataInFf <= dma_crc_pkg::DATA_RESET;
        end else if (softResetFf) begin
            dataInFf <= dma_crc_pkg::DATA_RESET;
        end else if (wrData) begin
            dataInFf <= merge(dataInFf, wdata, wMask); // R1
        end
    end

    // busy: set wins over clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busyFf <= 1'b0;
        end else if (softResetFf) begin
            busyFf <= 1'b0;
        end else if (regPath && wrData) begin
            busyFf <= 1'b1; // R18
        end else if (chanPath && channelEnabled && !busyFf) begin
            busyFf <= 1'b1; // R15
        end else if (regPath && wrStatus && wMask[0] && wdata[dma_crc_pkg::BUSY_BIT]) begin
            busyFf <= 1'b0; // R18
        end else if (chanPath && (channelCrcDone || !channelEnabled)) begin
            busyFf <= 1'b0; // R15
        end else if (!chkOnFf) begin
            busyFf <= 1'b0; // R14
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            zeroFf <= 1'b0;
        end else if (softResetFf || (wrCfg && !busyFf && wMask[dma_crc_pkg::SRC_LSB])) begin
            zeroFf <= 1'b0;
        end else if (engDone) begin
            zeroFf <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dbgRunFf <= 1'b0;
        end else if (wrDbg && wMask[0]) begin
            dbgRunFf <= wdata[0];
        end
    end

    assign engStart = chkOnFf && ((regPath && wrData) || (chanPath && channelBeatValid));
    assign engWord  = (regPath && wrData) ? merge(dataInFf, wdata, wMask) : channelBeatData;
    assign engClear = softResetFf || (wrCfg && !busyFf && wMask[dma_crc_pkg::SRC_LSB]);

    crc_byte_engine engine (
        .clk    (clk),
        .resetn (resetn),
        .clear  (engClear),
        .start  (engStart),
        .word   (engWord),
        .width  (cfgFf.width),
        .poly   (cfgFf.poly),
        .active (),
        .done   (engDone),
        .result (result)
    );

    // read data one cycle after the strobe; reserved bits zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdataFf <= 32'h00000000;
        end else if (!req.rd) begin
            rdataFf <= 32'h00000000;
        end else if (req.addr == dma_crc_pkg::ADDR_CONTROLLER_CONTROL) begin
            rdataFf <= {20'h0, levelEnableFf, 5'h0, chkOnFf, xferOnFf, softResetFf}; // R4
        end else if (req.addr == dma_crc_pkg::ADDR_CHECKSUM_CONTROL) begin
            rdataFf <= {18'h0, cfgFf.src, 4'h0, cfgFf.poly, cfgFf.width}; // R4
        end else if (req.addr == dma_crc_pkg::ADDR_CHECKSUM_DATA_INPUT) begin
            rdataFf <= dataInFf;
        end else if (req.addr == dma_crc_pkg::ADDR_CHECKSUM_RESULT) begin
            rdataFf <= result;
        end else if (req.addr == dma_crc_pkg::ADDR_CHECKSUM_STATUS) begin
            rdataFf <= {30'h0, zeroFf && (result == 32'h00000000), busyFf};
        end else if (req.addr == dma_crc_pkg::ADDR_DEBUG_HALT_CONTROL) begin
            rdataFf <= {31'h0, dbgRunFf};
        end else begin
            rdataFf <= 32'h00000000;
        end
    end

    assign rdata            = rdataFf;
    assign accessError      = errFf;
    assign levelGrantable   = levelRequest & levelEnableFf; // R5
    assign transferEngineOn = xferOnFf;
    assign checksumBusyFlag = busyFf;

    a_srst_error: assert property (@(posedge clk) disable iff (!resetn) // R11
        srstHit && (xferOnFf || chkOnFf) |=> accessError && !softResetFf) else $error("soft reset not refused");
    a_srst_clears: assert property (@(posedge clk) disable iff (!resetn) // R10
        softResetFf |=> levelEnableFf == 4'h0 && cfgFf == '0) else $error("soft reset left state");
    a_chk_hold: assert property (@(posedge clk) disable iff (!resetn) // R6
        chkOnFf && busyFf && !softResetFf |=> chkOnFf) else $error("checksum disabled while busy");
    a_drain_hold: assert property (@(posedge clk) disable iff (!resetn) // R8
        xferStateFf == dma_crc_pkg::XFER_DRAIN && !(burstDone && bufferEmpty) && !softResetFf |=> transferEngineOn)
        else $error("transfer enable dropped early");
    a_src_lock: assert property (@(posedge clk) disable iff (!resetn) // R14
        busyFf && !softResetFf |=> $stable(cfgFf.src)) else $error("source changed while busy");
    a_busy_set: assert property (@(posedge clk) disable iff (!resetn) // R18
        regPath && wrData && !softResetFf |=> checksumBusyFlag) else $error("busy not set");
    a_gate_level: assert property (@(posedge clk) disable iff (!resetn) // R5
        wrCtrl && !srstHit && wMask[dma_crc_pkg::LVL_LSB + 1] && !wdata[dma_crc_pkg::LVL_LSB + 1]
        |=> !levelGrantable[1]) else $error("disabled level passed");
    a_abort_off: assert property (@(posedge clk) disable iff (!resetn) // R8
        transferAbort |-> !transferEngineOn) else $error("enable stayed after abort");
    a_srst_once: assert property (@(posedge clk) disable iff (!resetn) // R12
        softResetFf && !srstHit |=> !softResetFf) else $error("soft reset stuck");
    a_byte_rate: assert property (@(posedge clk) disable iff (!resetn) // R19
        engStart && cfgFf.width == dma_crc_pkg::BEAT_WORD && !engClear ##1 !engStart[*3] |=> engDone)
        else $error("word beat not four cycles");
    a_read_zero: assert property (@(posedge clk) disable iff (!resetn) // R4
        req.rd && req.addr == dma_crc_pkg::ADDR_CONTROLLER_CONTROL |=> (rdata[15:12] == 4'h0) && (rdata[7:3] == 5'h0))
        else $error("reserved bits not zero");
    c_soft_reset: cover property (@(posedge clk) disable iff (!resetn) softResetFf);
    c_drain: cover property (@(posedge clk) disable iff (!resetn) transferAbort);
    c_crc_done: cover property (@(posedge clk) disable iff (!resetn) engDone && regPath);
    c_srst_error: cover property (@(posedge clk) disable iff (!resetn) accessError);
    c_src_lock: cover property (@(posedge clk) disable iff (!resetn) busyFf && wrCfg);
endmodule : dma_crc_global_control
`default_nettype wire

// ==== tb/far_side_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        runXfer,
    output logic             transferActive,
    output logic             burstDone,
    output logic             bufferEmpty,
    output logic             channelBeatValid,
    output logic [31:0]      channelBeatData,
    output logic             channelEnabled,
    output logic             channelCrcDone
);
    logic [3:0] beatsLeft;
    // one burst of eight beats per request
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            beatsLeft <= 4'h0;
        end else if (runXfer && beatsLeft == 4'h0) begin
            beatsLeft <= 4'h8;
        end else if (beatsLeft != 4'h0) begin
            beatsLeft <= beatsLeft - 4'h1;
        end
    end
    assign transferActive   = beatsLeft != 4'h0;
    assign burstDone        = beatsLeft == 4'h1;
    assign bufferEmpty      = beatsLeft < 4'h2;
    assign channelBeatValid = 1'b0;
    // beat data toggles only while a burst runs and is all zero when idle; channelBeatValid is held low, so no beat is ever sent
    assign channelBeatData  = {32{beatsLeft[0]}};
    assign channelEnabled   = 1'b0;
    assign channelCrcDone   = 1'b0;
endmodule : far_side_model
`default_nettype wire

// ==== tb/dma_crc_global_control_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module dma_crc_global_control_tb_top;
    logic        clk, resetn, wrStrobe, rdStrobe, writeProtect, runXfer, rdDly;
    logic        accessError, transferAbort, transferEngineOn, checksumBusyFlag;
    logic        transferActive, burstDone, bufferEmpty, beatValid, chanOn, chanDone;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, beatData, v;
    logic [3:0]  byteEn, levelRequest, levelGrantable;
    logic [5:0]  srcs [4] = '{6'h00, 6'h01, 6'h20, 6'h3F};
    logic [31:0] expQ [$];
    int          seed = 81;
    int          cmp_count, miscompares, cycles;

    dma_crc_global_control u_dma_crc_global_control (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .byteEn(byteEn), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdata(rdata), .accessError(accessError),
        .writeProtect(writeProtect), .levelRequest(levelRequest), .levelGrantable(levelGrantable),
        .transferActive(transferActive), .burstDone(burstDone), .bufferEmpty(bufferEmpty),
        .transferAbort(transferAbort), .transferEngineOn(transferEngineOn), .channelBeatValid(beatValid),
        .channelBeatData(beatData), .channelEnabled(chanOn), .channelCrcDone(chanDone),
        .checksumBusyFlag(checksumBusyFlag));
    far_side_model u_far_side_model (.clk(clk), .resetn(resetn), .runXfer(runXfer),
        .transferActive(transferActive), .burstDone(burstDone), .bufferEmpty(bufferEmpty),
        .channelBeatValid(beatValid), .channelBeatData(beatData), .channelEnabled(chanOn),
        .channelCrcDone(chanDone));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        addr     <= a;
        wdata    <= d;
        byteEn   <= be;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr     <= a;
        rdStrobe <= 1'b1;
        expQ.push_back(e);
        @(posedge clk);
        rdStrobe <= 1'b0;
    endtask : rd
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        rdDly <= rdStrobe;
        if (rdDly) chk(rdata, expQ.pop_front());
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            wrap_up();
        end
    end

    initial begin
        {resetn, wrStrobe, rdStrobe, writeProtect, runXfer} = '0;
        {addr, wdata, byteEn, levelRequest} = '0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        rd(dma_crc_pkg::ADDR_CONTROLLER_CONTROL, 32'h0);
        rd(dma_crc_pkg::ADDR_CHECKSUM_CONTROL, 32'h0);
        rd(dma_crc_pkg::ADDR_CHECKSUM_DATA_INPUT, 32'h0);
        wr(dma_crc_pkg::ADDR_CONTROLLER_CONTROL, 32'h00000F06, 4'hF);
        rd(dma_crc_pkg::ADDR_CONTROLLER_CONTROL, 32'h00000F06);
        wr(dma_crc_pkg::ADDR_CONTROLLER_CONTROL, 32'h00000500, 4'h2);
        rd(dma_crc_pkg::ADDR_CONTROLLER_CONTROL, 32'h00000506);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            levelRequest <= 4'($random(seed));
            #1 chk({28'h0, levelGrantable}, {28'h0, levelRequest & 4'h5});
        end
        $display("test enables done");
        wr(dma_crc_pkg::ADDR_CONTROLLER_CONTROL, 32'h00000507, 4'hF);
        #1 chk({31'h0, accessError}, 32'h1);
        rd(dma_crc_pkg::ADDR_CONTROLLER_CONTROL, 32'h00000506);
        @(posedge clk);
        runXfer <= 1'b1;
        @(posedge clk);
        runXfer <= 1'b0;
        wr(dma_crc_pkg::ADDR_CONTROLLER_CONTROL, 32'h00000504, 4'hF);
        rd(dma_crc_pkg::ADDR_CONTROLLER_CONTROL, 32'h00000506);
        for (int i = 0; i < 20 && transferAbort !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        #1 chk({31'h0, transferAbort}, 32'h1);
        chk({31'h0, transferEngineOn}, 32'h0);
        rd(dma_crc_pkg::ADDR_CONTROLLER_CONTROL, 32'h00000504);
        $display("test drain done");
        foreach (srcs[s]) for (int p = 0; p < 2; p++) for (int w = 0; w < 3; w++) begin
            v = {18'h0, srcs[s], 4'h0, 2'(p), 2'(w)};
            wr(dma_crc_pkg::ADDR_CHECKSUM_CONTROL, v, 4'hF);
            rd(dma_crc_pkg::ADDR_CHECKSUM_CONTROL, v);
        end
        // configure before data goes in
        wr(dma_crc_pkg::ADDR_CHECKSUM_CONTROL, 32'h00000106, 4'hF);
        writeProtect <= 1'b1;
        wr(dma_crc_pkg::ADDR_CHECKSUM_CONTROL, 32'h00000005, 4'hF);
        writeProtect <= 1'b0;
        rd(dma_crc_pkg::ADDR_CHECKSUM_CONTROL, 32'h00000106);
        wr(dma_crc_pkg::ADDR_CHECKSUM_DATA_INPUT, 32'($random(seed)), 4'hF);
        #1 chk({31'h0, checksumBusyFlag}, 32'h1);
        wr(dma_crc_pkg::ADDR_CHECKSUM_CONTROL, 32'h00002006, 4'hF);
        rd(dma_crc_pkg::ADDR_CHECKSUM_CONTROL, 32'h00000106);
        wr(dma_crc_pkg::ADDR_CONTROLLER_CONTROL, 32'h00000500, 4'hF);
        rd(dma_crc_pkg::ADDR_CONTROLLER_CONTROL, 32'h00000504);
        wr(dma_crc_pkg::ADDR_CHECKSUM_STATUS, 32'h00000001, 4'hF);
        #1 chk({31'h0, checksumBusyFlag}, 32'h0);
        wr(dma_crc_pkg::ADDR_CONTROLLER_CONTROL, 32'h00000500, 4'hF);
        rd(dma_crc_pkg::ADDR_CONTROLLER_CONTROL, 32'h00000500);
        $display("test checksum path done");
        wr(dma_crc_pkg::ADDR_CONTROLLER_CONTROL, 32'h00000501, 4'hF);
        repeat (4) @(posedge clk);
        rd(dma_crc_pkg::ADDR_CONTROLLER_CONTROL, 32'h0);
        rd(dma_crc_pkg::ADDR_CHECKSUM_CONTROL, 32'h0);
        repeat (3) @(posedge clk);
        $display("test soft reset done");
        wrap_up();
    end
endmodule : dma_crc_global_control_tb_top
`default_nettype wire
